// ===== src/mrs_pkg.sv
// shared constants, operation codes and carrier structs of the rotate/skip/subtract unit
package mrs_pkg;

  // ----------------------------------------------------------------------
  // apb register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int unsigned APB_AW = 12;
  localparam logic [11:0] ADDR_CMD = 12'h000;
  localparam logic [11:0] ADDR_IMM = 12'h004;
  localparam logic [11:0] ADDR_WREG = 12'h008;
  localparam logic [11:0] ADDR_FLAGS = 12'h00C;
  localparam logic [11:0] ADDR_TPTR = 12'h010;
  localparam logic [11:0] ADDR_TABLE_HIGH_LATCH = 12'h014;
  localparam logic [11:0] ADDR_STATUS = 12'h018;
  localparam logic [11:0] ADDR_PADDR = 12'h020;
  localparam logic [11:0] ADDR_PDATA = 12'h024;
  localparam logic [11:0] ADDR_DMEM_BASE = 12'h100;
  localparam logic [11:0] ADDR_DMEM_LAST = 12'h17C;

  // ----------------------------------------------------------------------
  // memories
  // ----------------------------------------------------------------------
  localparam int unsigned DMEM_AW = 5;
  localparam int unsigned DMEM_DEPTH = 32;
  localparam int unsigned PMEM_AW = 9;
  localparam int unsigned PMEM_DEPTH = 512;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_ADDR_LSB = 8;
  localparam int unsigned CMD_BIT_LSB = 16;
  localparam int unsigned FLG_CY = 0;
  localparam int unsigned FLG_NIB = 1;
  localparam int unsigned FLG_Z = 2;
  localparam int unsigned FLG_WRAP = 3;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_SKIP = 1;
  localparam int unsigned ST_BADOP = 2;
  localparam int unsigned ST_LAST_SKIP = 3;
  localparam int unsigned TPTR_HIGH_BIT = 8;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [8:0] TPTR_RST = 9'h000;
  localparam logic [7:0] TABLE_HIGH_LATCH_RST = 8'h00;
  localparam logic [31:0] CMD_RST = 32'h0000_0000;

  typedef enum logic [4:0] {
    OP_ROTATE_LEFT_TO_W, OP_ROTATE_LEFT_THRU_CY, OP_ROTATE_LEFT_CY_TO_W,
    OP_ROTATE_RIGHT_INPLACE, OP_ROTATE_RIGHT_TO_W, OP_ROTATE_RIGHT_THRU_CY,
    OP_ROTATE_RIGHT_CY_TO_W, OP_SUBTRACT_CY_TO_W, OP_SUBTRACT_CY_TO_MEM,
    OP_SUBTRACT_TO_W, OP_SUBTRACT_IMM_TO_W, OP_SUBTRACT_TO_MEM,
    OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO_COPY, OP_INCREMENT_SKIP_ZERO,
    OP_INCREMENT_SKIP_ZERO_COPY, OP_SKIP_BIT_SET, OP_SKIP_BIT_CLEAR,
    OP_SKIP_IF_ZERO, OP_SKIP_IF_ZERO_COPY, OP_SET_BYTE, OP_SET_BIT,
    OP_NIBBLE_EXCHANGE, OP_NIBBLE_EXCHANGE_COPY, OP_TABLE_READ,
    OP_TABLE_READ_LAST_PAGE, OP_XOR_TO_W
  } mrs_op_t;

  typedef enum {ST_IDLE, ST_EXEC, ST_DUMMY} mrs_state_t;

  typedef struct packed {
    mrs_op_t op;
    logic [7:0] w;
    logic [7:0] mem;
    logic [7:0] imm;
    logic [2:0] bit_sel;
    logic cy;
    logic [15:0] tbl_word;
  } mrs_alu_in_t;

  typedef struct packed {
    logic [7:0] res;
    logic [7:0] table_high_latch;
    logic cy;
    logic nib;
    logic wrap;
    logic z;
    logic wr_w;
    logic wr_mem;
    logic wr_table_high_latch;
    logic upd_cy;
    logic upd_arith;
    logic upd_z;
    logic skip;
    logic bad_op;
  } mrs_alu_out_t;

endpackage : mrs_pkg

// ===== src/mrs_alu.sv
// combinational datapath: result, flags, destination and skip decision per operation
`timescale 1ns/1ps
module mrs_alu
  import mrs_pkg::*;
(
  input wire mrs_alu_in_t alu_i,
  output mrs_alu_out_t alu_o
);

  logic [7:0] sub_b;
  logic sub_cin;
  logic [8:0] diff;
  logic [4:0] nib_diff;
  logic [7:0] bit_mask;

  // carry in is 1 for plain subtraction, the carry flag for the borrow forms
  assign sub_b = (alu_i.op == OP_SUBTRACT_IMM_TO_W) ? alu_i.imm : alu_i.mem;
  assign sub_cin = (alu_i.op == OP_SUBTRACT_CY_TO_W || alu_i.op == OP_SUBTRACT_CY_TO_MEM) ? alu_i.cy : 1'b1;
  assign diff = {1'b0, alu_i.w} + {1'b0, ~sub_b} + {8'h00, sub_cin};
  assign nib_diff = {1'b0, alu_i.w[3:0]} + {1'b0, ~sub_b[3:0]} + {4'h0, sub_cin};
  assign bit_mask = 8'h01 << alu_i.bit_sel;

  always_comb begin
    alu_o = '0;
    alu_o.cy = alu_i.cy;
    alu_o.table_high_latch = alu_i.tbl_word[15:8];
    unique case (alu_i.op)
      OP_ROTATE_LEFT_TO_W: begin
        alu_o.res = {alu_i.mem[6:0], alu_i.mem[7]};
        alu_o.wr_w = 1'b1;
      end
      OP_ROTATE_LEFT_THRU_CY, OP_ROTATE_LEFT_CY_TO_W: begin
        alu_o.res = {alu_i.mem[6:0], alu_i.cy};
        alu_o.cy = alu_i.mem[7];
        alu_o.upd_cy = 1'b1;
        alu_o.wr_mem = (alu_i.op == OP_ROTATE_LEFT_THRU_CY);
        alu_o.wr_w = (alu_i.op == OP_ROTATE_LEFT_CY_TO_W);
      end
      OP_ROTATE_RIGHT_INPLACE, OP_ROTATE_RIGHT_TO_W: begin
        alu_o.res = {alu_i.mem[0], alu_i.mem[7:1]};
        alu_o.wr_mem = (alu_i.op == OP_ROTATE_RIGHT_INPLACE);
        alu_o.wr_w = (alu_i.op == OP_ROTATE_RIGHT_TO_W);
      end
      OP_ROTATE_RIGHT_THRU_CY, OP_ROTATE_RIGHT_CY_TO_W: begin
        alu_o.res = {alu_i.cy, alu_i.mem[7:1]};
        alu_o.cy = alu_i.mem[0];
        alu_o.upd_cy = 1'b1;
        alu_o.wr_mem = (alu_i.op == OP_ROTATE_RIGHT_THRU_CY);
        alu_o.wr_w = (alu_i.op == OP_ROTATE_RIGHT_CY_TO_W);
      end
      OP_SUBTRACT_CY_TO_W, OP_SUBTRACT_CY_TO_MEM, OP_SUBTRACT_TO_W, OP_SUBTRACT_IMM_TO_W,
      OP_SUBTRACT_TO_MEM: begin
        alu_o.res = diff[7:0];
        alu_o.cy = diff[8];
        alu_o.nib = nib_diff[4];
        alu_o.wrap = (alu_i.w[7] ^ sub_b[7]) & (alu_i.w[7] ^ diff[7]);
        alu_o.upd_cy = 1'b1;
        alu_o.upd_arith = 1'b1;
        alu_o.upd_z = 1'b1;
        alu_o.wr_mem = (alu_i.op == OP_SUBTRACT_CY_TO_MEM || alu_i.op == OP_SUBTRACT_TO_MEM);
        alu_o.wr_w = ~alu_o.wr_mem;
      end
      OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO_COPY: begin
        alu_o.res = alu_i.mem - 8'h01;
        alu_o.skip = (alu_o.res == 8'h00);
        alu_o.wr_mem = (alu_i.op == OP_DECREMENT_SKIP_ZERO);
        alu_o.wr_w = (alu_i.op == OP_DECREMENT_SKIP_ZERO_COPY);
      end
      OP_INCREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO_COPY: begin
        alu_o.res = alu_i.mem + 8'h01;
        alu_o.skip = (alu_o.res == 8'h00);
        alu_o.wr_mem = (alu_i.op == OP_INCREMENT_SKIP_ZERO);
        alu_o.wr_w = (alu_i.op == OP_INCREMENT_SKIP_ZERO_COPY);
      end
      OP_SKIP_BIT_SET: alu_o.skip = |(alu_i.mem & bit_mask);
      OP_SKIP_BIT_CLEAR: alu_o.skip = ~|(alu_i.mem & bit_mask);
      OP_SKIP_IF_ZERO, OP_SKIP_IF_ZERO_COPY: begin
        alu_o.res = alu_i.mem;
        alu_o.skip = (alu_i.mem == 8'h00);
        alu_o.wr_mem = (alu_i.op == OP_SKIP_IF_ZERO);
        alu_o.wr_w = (alu_i.op == OP_SKIP_IF_ZERO_COPY);
      end
      OP_SET_BYTE: begin
        alu_o.res = 8'hFF;
        alu_o.wr_mem = 1'b1;
      end
      OP_SET_BIT: begin
        alu_o.res = alu_i.mem | bit_mask;
        alu_o.wr_mem = 1'b1;
      end
      OP_NIBBLE_EXCHANGE, OP_NIBBLE_EXCHANGE_COPY: begin
        alu_o.res = {alu_i.mem[3:0], alu_i.mem[7:4]};
        alu_o.wr_mem = (alu_i.op == OP_NIBBLE_EXCHANGE);
        alu_o.wr_w = (alu_i.op == OP_NIBBLE_EXCHANGE_COPY);
      end
      OP_TABLE_READ, OP_TABLE_READ_LAST_PAGE: begin
        alu_o.res = alu_i.tbl_word[7:0];
        alu_o.wr_mem = 1'b1;
        alu_o.wr_table_high_latch = 1'b1;
      end
      OP_XOR_TO_W: begin
        alu_o.res = alu_i.w ^ alu_i.mem;
        alu_o.wr_w = 1'b1;
        alu_o.upd_z = 1'b1;
      end
      default: alu_o.bad_op = 1'b1;
    endcase
    alu_o.z = (alu_o.res == 8'h00);
  end

endmodule : mrs_alu

// ===== src/mrs_exec.sv
// top of the rotate/skip/subtract execution unit with its apb register file and memories
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
module mrs_exec
  import mrs_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic EXEC_BUSY,
  output logic SKIP_NEXT
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [7:0] dmem [DMEM_DEPTH];
  logic [15:0] pmem [PMEM_DEPTH];

  mrs_state_t state_reg;
  mrs_state_t state_next;
  logic [31:0] cmd_reg;
  logic [7:0] imm_reg;
  logic [7:0] wreg_reg;
  logic [3:0] flags_reg;
  logic [8:0] tptr_reg;
  logic [7:0] table_high_latch_reg;
  logic [PMEM_AW-1:0] paddr_reg;
  logic skip_sticky_reg;
  logic badop_sticky_reg;
  logic last_skip_reg;
  logic skip_out_reg;
  logic [31:0] prdata_reg;
  logic err_reg;

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic setup_phase;
  logic access_phase;
  logic wr_go;
  logic hit_known;
  logic hit_dmem;
  logic busy;
  logic [DMEM_AW-1:0] apb_dmem_idx;
  logic refuse;

  assign setup_phase = PSEL & ~PENABLE;
  assign access_phase = PSEL & PENABLE;
  assign busy = (state_reg != ST_IDLE);
  assign hit_dmem = (PADDR >= ADDR_DMEM_BASE) && (PADDR <= ADDR_DMEM_LAST) && (PADDR[1:0] == 2'b00);
  assign apb_dmem_idx = PADDR[DMEM_AW+1:2];
  assign hit_known = hit_dmem || PADDR == ADDR_CMD || PADDR == ADDR_IMM || PADDR == ADDR_WREG
                     || PADDR == ADDR_FLAGS || PADDR == ADDR_TPTR || PADDR == ADDR_TABLE_HIGH_LATCH
                     || PADDR == ADDR_STATUS || PADDR == ADDR_PADDR || PADDR == ADDR_PDATA;
  // a write that would race the datapath is refused rather than silently lost
  assign refuse = ~hit_known || (PWRITE && busy && PADDR != ADDR_STATUS);
  // writes take effect only at the completing edge of the access phase
  assign wr_go = access_phase & PWRITE & ~err_reg;

  assign PREADY = 1'b1;
  assign PSLVERR = access_phase & err_reg;
  assign PRDATA = prdata_reg;
  assign EXEC_BUSY = busy;
  assign SKIP_NEXT = skip_out_reg;

  // ----------------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------------
  mrs_alu_in_t alu_in;
  mrs_alu_out_t alu_out;
  logic [DMEM_AW-1:0] op_addr;
  logic [PMEM_AW-1:0] tbl_addr;
  logic commit;

  assign op_addr = cmd_reg[CMD_ADDR_LSB +: DMEM_AW];
  // last page ignores the high pointer and forces the top page bit
  assign tbl_addr = (mrs_op_t'(cmd_reg[CMD_OP_LSB +: 5]) == OP_TABLE_READ_LAST_PAGE) ?
                    {1'b1, tptr_reg[7:0]} : tptr_reg;
  assign commit = (state_reg == ST_EXEC);

  always_comb begin
    alu_in.op = mrs_op_t'(cmd_reg[CMD_OP_LSB +: 5]);
    alu_in.w = wreg_reg;
    alu_in.mem = dmem[op_addr];
    alu_in.imm = imm_reg;
    alu_in.bit_sel = cmd_reg[CMD_BIT_LSB +: 3];
    alu_in.cy = flags_reg[FLG_CY];
    alu_in.tbl_word = pmem[tbl_addr];
  end

  mrs_alu u_alu (
    .alu_i(alu_in),
    .alu_o(alu_out)
  );

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (wr_go && PADDR == ADDR_CMD) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        // a taken skip spends a second cycle on the squashed fetch
        state_next = (alu_out.skip && !alu_out.bad_op) ? ST_DUMMY : ST_IDLE;
      end
      ST_DUMMY: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // squash pulse stands for the dummy cycle only
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      skip_out_reg <= 1'b0;
    end else begin
      skip_out_reg <= commit & alu_out.skip & ~alu_out.bad_op;
    end
  end

  // ----------------------------------------------------------------------
  // command and operand registers
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      cmd_reg <= CMD_RST;
    end else if (wr_go && PADDR == ADDR_CMD) begin
      cmd_reg <= PWDATA;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      imm_reg <= WREG_RST;
    end else if (wr_go && PADDR == ADDR_IMM) begin
      imm_reg <= PWDATA[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // working register and flags
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      wreg_reg <= WREG_RST;
    end else if (commit && alu_out.wr_w) begin
      wreg_reg <= alu_out.res;
    end else if (wr_go && PADDR == ADDR_WREG) begin
      wreg_reg <= PWDATA[7:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      flags_reg <= FLAGS_RST;
    end else if (commit) begin
      // each flag moves only when its operation group says so
      if (alu_out.upd_cy) begin
        flags_reg[FLG_CY] <= alu_out.cy;
      end
      if (alu_out.upd_arith) begin
        flags_reg[FLG_NIB] <= alu_out.nib;
        flags_reg[FLG_WRAP] <= alu_out.wrap;
      end
      if (alu_out.upd_z) begin
        flags_reg[FLG_Z] <= alu_out.z;
      end
    end else if (wr_go && PADDR == ADDR_FLAGS) begin
      flags_reg <= PWDATA[3:0];
    end
  end

  // ----------------------------------------------------------------------
  // table pointer and high latch
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      tptr_reg <= TPTR_RST;
    end else if (wr_go && PADDR == ADDR_TPTR) begin
      tptr_reg <= PWDATA[TPTR_HIGH_BIT:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      table_high_latch_reg <= TABLE_HIGH_LATCH_RST;
    end else if (commit && alu_out.wr_table_high_latch) begin
      table_high_latch_reg <= alu_out.table_high_latch;
    end
  end

  // ----------------------------------------------------------------------
  // memories
  // ----------------------------------------------------------------------
  // software writes are refused while busy, so the two writers never meet
  always_ff @(posedge REF_CLK) begin
    if (commit && alu_out.wr_mem && !alu_out.bad_op) begin
      dmem[op_addr] <= alu_out.res;
    end else if (wr_go && hit_dmem) begin
      dmem[apb_dmem_idx] <= PWDATA[7:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      paddr_reg <= '0;
    end else if (wr_go && PADDR == ADDR_PADDR) begin
      paddr_reg <= PWDATA[PMEM_AW-1:0];
    end else if (wr_go && PADDR == ADDR_PDATA) begin
      paddr_reg <= paddr_reg + 9'h001;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (wr_go && PADDR == ADDR_PDATA) begin
      pmem[paddr_reg] <= PWDATA[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // status
  // ----------------------------------------------------------------------
  logic skip_set;
  logic bad_set;
  logic stat_wr;

  assign skip_set = commit & alu_out.skip & ~alu_out.bad_op;
  assign bad_set = commit & alu_out.bad_op;
  assign stat_wr = wr_go && PADDR == ADDR_STATUS;

  // set wins over a same-cycle write-one-to-clear
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      skip_sticky_reg <= 1'b0;
    end else if (skip_set) begin
      skip_sticky_reg <= 1'b1;
    end else if (stat_wr && PWDATA[ST_SKIP]) begin
      skip_sticky_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      badop_sticky_reg <= 1'b0;
    end else if (bad_set) begin
      badop_sticky_reg <= 1'b1;
    end else if (stat_wr && PWDATA[ST_BADOP]) begin
      badop_sticky_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      last_skip_reg <= 1'b0;
    end else if (commit) begin
      last_skip_reg <= skip_set;
    end
  end

  // ----------------------------------------------------------------------
  // apb read data and error, captured in the setup cycle
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_dmem) begin
      rd_mux[7:0] = dmem[apb_dmem_idx];
    end else begin
      unique case (PADDR)
        ADDR_CMD: rd_mux = cmd_reg;
        ADDR_IMM: rd_mux[7:0] = imm_reg;
        ADDR_WREG: rd_mux[7:0] = wreg_reg;
        ADDR_FLAGS: rd_mux[3:0] = flags_reg;
        ADDR_TPTR: rd_mux[8:0] = tptr_reg;
        ADDR_TABLE_HIGH_LATCH: rd_mux[7:0] = table_high_latch_reg;
        ADDR_STATUS: begin
          rd_mux[ST_BUSY] = busy;
          rd_mux[ST_SKIP] = skip_sticky_reg;
          rd_mux[ST_BADOP] = badop_sticky_reg;
          rd_mux[ST_LAST_SKIP] = last_skip_reg;
        end
        ADDR_PADDR: rd_mux[PMEM_AW-1:0] = paddr_reg;
        ADDR_PDATA: rd_mux[15:0] = pmem[paddr_reg];
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      prdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg <= (PWRITE || refuse) ? 32'h0000_0000 : rd_mux;
      err_reg <= refuse;
    end
  end

endmodule : mrs_exec

// ===== dv/mrs_exec_asserts.sv
// port-level timing checks of the rotate/skip/subtract execution unit
`timescale 1ns/1ps
module mrs_exec_asserts
  import mrs_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic EXEC_BUSY,
  input wire logic SKIP_NEXT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  logic cmd_wr;
  // a refused command (error latched in its setup cycle) starts nothing
  assign cmd_wr = PSEL && PENABLE && PWRITE && PADDR == ADDR_CMD && !EXEC_BUSY && !PSLVERR;
  a_bus_ready: assert property (PREADY) else $error("pready low");
  a_err_access: assert property (PSLVERR |-> PSEL && PENABLE && (PWRITE || PRDATA == 32'h0))
    else $error("error outside access phase");
  a_cmd_starts_op: assert property (cmd_wr |=> EXEC_BUSY) else $error("command did not start");
  a_busy_needs_cmd: assert property ($rose(EXEC_BUSY) |-> $past(cmd_wr)) else $error("busy without command");
  a_busy_bounded: assert property ($rose(EXEC_BUSY) |-> ##[1:2] !EXEC_BUSY) else $error("busy too long");
  a_dummy_second: assert property ($rose(EXEC_BUSY) |-> !SKIP_NEXT) else $error("squash in first cycle");
  a_skip_in_busy: assert property (SKIP_NEXT |-> EXEC_BUSY && $past(EXEC_BUSY)) else $error("squash not busy");
  a_skip_ends: assert property (SKIP_NEXT |=> !EXEC_BUSY && !SKIP_NEXT) else $error("squash not one cycle");
  a_busy_refuse: assert property (PSEL && PENABLE && PWRITE && EXEC_BUSY
    && PADDR != ADDR_STATUS |-> PSLVERR)
    else $error("write while busy accepted");
endmodule : mrs_exec_asserts

bind mrs_exec mrs_exec_asserts mrs_exec_asserts_inst (.REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .EXEC_BUSY(EXEC_BUSY), .SKIP_NEXT(SKIP_NEXT));

// ===== dv/mrs_apb_bfm.sv
// apb master model standing in for the core sequencer
`timescale 1ns/1ps
module mrs_apb_bfm (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // keep leaves psel up so the next setup follows the access at once
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic keep,
    output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no wait-state limit here: only the bench timeout ends a stalled access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    if (!keep) begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
      @(posedge clk);
    end
  endtask : xfer
endmodule : mrs_apb_bfm

// ===== dv/test_mrs_exec.sv
// self-checking bench of the rotate/skip/subtract execution unit
`timescale 1ns/1ps
module test_mrs_exec import mrs_pkg::*;;
  localparam logic [11:0] DA = 12'h114;
  logic REF_CLK = 1'b0;
  logic NRST = 1'b0;
  logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, EXEC_BUSY, SKIP_NEXT;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  int n_fail = 0;
  int samples_checked = 0;
  int n_skip = 0;
  int cycles = 0;
  always #25 REF_CLK = ~REF_CLK;
  mrs_exec mrs_exec_inst (.REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .EXEC_BUSY(EXEC_BUSY), .SKIP_NEXT(SKIP_NEXT));
  mrs_apb_bfm bfm_inst (.clk(REF_CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR),
    .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));
  always @(posedge REF_CLK) begin
    cycles++;
    if (SKIP_NEXT === 1'b1) n_skip++;
    if (cycles == 6000) begin
      n_fail++;
      stop_test();
    end
  end
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    bfm_inst.xfer(1'b1, a, d, 1'b0, q, e);
    chk({31'h0, e}, 32'h0);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    bfm_inst.xfer(1'b0, a, 32'h0, 1'b0, q, e);
  endtask : rd
  // v = {op, bit, flags, working, byte}; x = {flags, working, byte, skips} expected afterwards
  task automatic ex(input logic [31:0] v, input logic [23:0] x);
    logic [31:0] q;
    int n;
    int s;
    wr(ADDR_WREG, {24'h0, v[15:8]});
    wr(ADDR_FLAGS, {28'h0, v[19:16]});
    wr(DA, {24'h0, v[7:0]});
    // snapshot instead of clearing: the squash counter has one writer only
    s = n_skip;
    wr(ADDR_CMD, {13'h0, v[22:20], 8'h05, 3'h0, v[28:24]});
    n = 0;
    do begin
      rd(ADDR_STATUS, q);
      n++;
    end while (q[ST_BUSY] !== 1'b0 && n < 8);
    chk({31'h0, q[ST_BUSY]}, 32'h0);
    chk(n_skip - s, {28'h0, x[3:0]});
    rd(ADDR_WREG, q);
    chk(q, {24'h0, x[19:12]});
    rd(ADDR_FLAGS, q);
    chk(q, {28'h0, x[23:20]});
    rd(DA, q);
    chk(q, {24'h0, x[11:4]});
  endtask : ex
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_rotate;
    ex(32'h000B_5569, 24'hBD_2690);
    ex(32'h010B_5569, 24'hA5_5D30);
    ex(32'h020B_5569, 24'hAD_3690);
    ex(32'h030B_5569, 24'hB5_5B40);
    ex(32'h040B_5569, 24'hBB_4690);
    ex(32'h050A_5569, 24'hB5_5340);
    ex(32'h060A_5569, 24'hB3_4690);
  endtask : t_rotate
  task automatic t_subtract;
    wr(ADDR_IMM, 32'h33);
    ex(32'h0700_5070, 24'h0D_F700);
    ex(32'h0801_5070, 24'h25_0E00);
    ex(32'h0900_8001, 24'h97_F010);
    ex(32'h0A00_3300, 24'h70_0000);
    ex(32'h0B00_1010, 24'h71_0000);
    ex(32'h1A0B_F0F0, 24'hF0_0F00);
    ex(32'h1A0F_0FF0, 24'hBF_FF00);
  endtask : t_subtract
  task automatic t_skip;
    ex(32'h0C0B_5501, 24'hB5_5001);
    ex(32'h0C0B_5502, 24'hB5_5010);
    ex(32'h0D0B_5501, 24'hB0_0011);
    ex(32'h0E0B_55FF, 24'hB5_5001);
    ex(32'h0F0B_55FE, 24'hBF_FFE0);
    ex(32'h103B_5508, 24'hB5_5081);
    ex(32'h102B_5508, 24'hB5_5080);
    ex(32'h113B_55F7, 24'hB5_5F71);
    ex(32'h114B_55F7, 24'hB5_5F70);
    ex(32'h120B_5500, 24'hB5_5001);
    ex(32'h130B_5540, 24'hB4_0400);
  endtask : t_skip
  task automatic t_misc;
    logic [31:0] q;
    ex(32'h140B_5512, 24'hB5_5FF0);
    ex(32'h155B_5581, 24'hB5_5A10);
    ex(32'h160B_5569, 24'hB5_5960);
    ex(32'h170B_5569, 24'hB9_6690);
    wr(ADDR_PADDR, 32'h0000_0123);
    wr(ADDR_PDATA, 32'h0000_BEEF);
    wr(ADDR_PADDR, 32'h0000_0023);
    wr(ADDR_PDATA, 32'h0000_CAFE);
    wr(ADDR_TPTR, 32'h0000_0023);
    ex(32'h180B_5500, 24'hB5_5FE0);
    rd(ADDR_TABLE_HIGH_LATCH, q);
    chk(q, 32'hCA);
    ex(32'h190B_5500, 24'hB5_5EF0);
    rd(ADDR_TABLE_HIGH_LATCH, q);
    chk(q, 32'hBE);
  endtask : t_misc
  task automatic t_bus;
    logic [31:0] q;
    logic e;
    wr(DA, 32'h0);
    wr(ADDR_WREG, 32'h55);
    bfm_inst.xfer(1'b1, ADDR_CMD, 32'h0000_0512, 1'b1, q, e);
    bfm_inst.xfer(1'b1, ADDR_WREG, 32'hAA, 1'b0, q, e);
    chk({31'h0, e}, 32'h1);
    rd(ADDR_WREG, q);
    chk(q, 32'h55);
    rd(ADDR_STATUS, q);
    chk(q, 32'hA);
    bfm_inst.xfer(1'b0, 12'h030, 32'h0, 1'b0, q, e);
    chk({q[30:0], e}, 32'h1);
    // illegal op code: no data or flag change, one busy cycle, sticky error bit
    ex(32'h1B0B_5569, 24'hB5_5690);
    rd(ADDR_STATUS, q);
    chk(q, 32'h6);
    wr(ADDR_STATUS, 32'h6);
    rd(ADDR_STATUS, q);
    chk(q, 32'h0);
  endtask : t_bus
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (8) @(posedge REF_CLK);
    NRST <= 1'b1;
    @(posedge REF_CLK);
    t_rotate();
    t_subtract();
    t_skip();
    t_misc();
    t_bus();
    stop_test();
  end
endmodule : test_mrs_exec
